// ### common/lec_pkg.sv
// Package: opcodes, operand classes and sizes of the edge contact scan logic
package lec_pkg;
   // Opcodes held in the program memory word
   localparam logic [3:0] OP_NOP   = 4'h0;
   localparam logic [3:0] OP_LOAD  = 4'h1;
   localparam logic [3:0] OP_LDR   = 4'h2;
   localparam logic [3:0] OP_SRISE = 4'h3;
   localparam logic [3:0] OP_SFALL = 4'h4;
   localparam logic [3:0] OP_PRISE = 4'h5;
   localparam logic [3:0] OP_PFALL = 4'h6;
   localparam logic [3:0] OP_FPULS = 4'h7;
   localparam logic [3:0] OP_END   = 4'hF;
   // Operand classes
   localparam logic [2:0] CLS_IN   = 3'h0;
   localparam logic [2:0] CLS_OUT  = 3'h1;
   localparam logic [2:0] CLS_AUX  = 3'h2;
   localparam logic [2:0] CLS_TMR  = 3'h3;
   localparam logic [2:0] CLS_CNT  = 3'h4;
   localparam logic [2:0] CLS_DATA = 3'h5;
   // Highest index per class; I/O indices are octal, 0..17 is 16 bits
   localparam logic [9:0] MAX_IN   = 10'h00F;
   localparam logic [9:0] MAX_OUT  = 10'h00F;
   localparam logic [9:0] MAX_AUX  = 10'h31F;
   localparam logic [9:0] MAX_TMR  = 10'h09F;
   localparam logic [9:0] MAX_CNT  = 10'h04F;
   localparam int         N_IN     = 16;
   localparam int         N_OUT    = 16;
   localparam int         N_AUX    = 800;
   localparam int         N_TMR    = 160;
   localparam int         N_CNT    = 80;
   localparam int         N_BIT    = 1072;
   localparam int         AW       = 8;
   localparam logic [AW-1:0] ADDR_START = 8'h00;
   localparam logic [AW-1:0] ADDR_RST   = 8'h00;
   // Base of each class in the flat bit space
   localparam logic [10:0] BASE_IN  = 11'h000;
   localparam logic [10:0] BASE_OUT = 11'h010;
   localparam logic [10:0] BASE_AUX = 11'h020;
   localparam logic [10:0] BASE_TMR = 11'h340;
   localparam logic [10:0] BASE_CNT = 11'h3E0;
   typedef enum logic [1:0]
   {
      LEC_IDLE  = 2'b00,
      LEC_FETCH = 2'b01,
      LEC_EXEC  = 2'b11,
      LEC_WRAP  = 2'b10
   } lec_state_type;
endpackage

// ### core/lec_operand_check.sv
// Operand class check and flattening into the bit space
`timescale 1ns/1ps
`default_nettype none
module lec_operand_check
(
   input  wire logic [2:0]  op_class,
   input  wire logic [9:0]  op_index,
   input  wire logic        coil_only,
   output logic             legal,
   output logic [10:0]      flat
);
   import lec_pkg::*;
   // Coil targets accept outputs and auxiliary relays only
   always_comb
   begin
      legal = 1'b0;
      flat  = 11'h000;
      case (op_class)
         CLS_IN :
         begin
            legal = !coil_only && op_index <= MAX_IN;
            flat  = BASE_IN + {1'b0, op_index};
         end
         CLS_OUT :
         begin
            legal = op_index <= MAX_OUT;
            flat  = BASE_OUT + {1'b0, op_index};
         end
         CLS_AUX :
         begin
            legal = op_index <= MAX_AUX;
            flat  = BASE_AUX + {1'b0, op_index};
         end
         CLS_TMR :
         begin
            legal = !coil_only && op_index <= MAX_TMR;
            flat  = BASE_TMR + {1'b0, op_index};
         end
         CLS_CNT :
         begin
            legal = !coil_only && op_index <= MAX_CNT;
            flat  = BASE_CNT + {1'b0, op_index};
         end
         default :
         begin
            legal = 1'b0;
            flat  = 11'h000;
         end
      endcase
   end
endmodule
`default_nettype wire

// ### core/lec_scan_core.sv
// Scan engine for edge contacts, falling-edge pulse and program end
//
// What this block does
// - Series rise contact ANDs result with contact off-to-on this scan.
// - Series fall contact ANDs result with contact on-to-off this scan.
// - Parallel rise contact ORs result with contact off-to-on this scan.
// - Parallel fall contact ORs result with contact on-to-off this scan.
// - Edge operands: inputs, outputs, relays, timers, counters; no data.
// - Each scan runs sequentially from address 0 to program end.
// - After program end, return to address 0 and start next scan while run is on; with run off, go idle.
// - Edge load replaces result with contact off-to-on and records contact state.
// - After power-up, rise contact true if contact already on.
`timescale 1ns/1ps
`default_nettype none
module lec_scan_core
(
   input  wire logic                         clock,
   input  wire logic                         reset,
   input  wire logic                         run,
   input  wire logic [lec_pkg::N_IN-1:0]     inputs,
   input  wire logic [lec_pkg::N_TMR-1:0]    timer_bits,
   input  wire logic [lec_pkg::N_CNT-1:0]    counter_bits,
   output logic [lec_pkg::AW-1:0]            prog_addr,
   input  wire logic [16:0]                  prog_word,
   output logic [lec_pkg::N_OUT-1:0]         outputs,
   output logic                              result,
   output logic                              scan_done,
   output logic                              operand_fault
);
   import lec_pkg::*;
   // Program word: opcode[16:13] class[12:10] index[9:0]
   lec_state_type           state;
   logic [1:0]              run_sync;
   logic [N_IN-1:0]         in_meta;
   logic [N_IN-1:0]         in_sync;
   logic [N_BIT-1:0]        bits;
   logic [2**AW-1:0]        edge_mem;
   logic [N_BIT-1:0]        fp_prev;
   logic                    acc;
   logic                    first_scan;
   logic [16:0]             ir;
   logic                    legal;
   logic [10:0]             flat;
   logic                    cur;
   logic                    was;
   logic                    rise;
   logic                    fall;
   logic                    coil_only;
   logic                    next_acc;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         run_sync <= 2'h0;
         in_meta  <= '0;
         in_sync  <= '0;
      end
      else
      begin
         run_sync <= {run_sync[0], run};
         in_meta  <= inputs;
         in_sync  <= in_meta;
      end
   end

   // ---------------------------------------------------------------
   // Operand decode and edge terms
   // ---------------------------------------------------------------
   assign coil_only = ir[16:13] == OP_FPULS;

   lec_operand_check u_check
   (
      .op_class  (ir[12:10]),
      .op_index  (ir[9:0]),
      .coil_only (coil_only),
      .legal     (legal),
      .flat      (flat)
   );

   function automatic logic pick(input logic [N_BIT-1:0] v,
                                 input logic [10:0] i);
      pick = v[i];
   endfunction

   assign cur = pick(bits, flat);
   // Edge memory is zero on the first scan, so a contact on at power-up
   // reads as a rising edge
   assign was = first_scan ? 1'b0 : edge_mem[prog_addr];
   assign rise = legal && cur && !was;
   assign fall = legal && !cur && was;

   always_comb
   begin
      next_acc = acc;
      case (ir[16:13])
         OP_LOAD  : next_acc = legal && cur;
         OP_LDR   : next_acc = rise;
         OP_SRISE : next_acc = acc && rise;
         OP_SFALL : next_acc = acc && fall;
         OP_PRISE : next_acc = acc || rise;
         OP_PFALL : next_acc = acc || fall;
         default  : next_acc = acc;
      endcase
   end

   // ---------------------------------------------------------------
   // Scan sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state     <= LEC_IDLE;
         prog_addr <= ADDR_RST;
         ir        <= 17'h00000;
         scan_done <= 1'b0;
      end
      else
      begin
         scan_done <= 1'b0;
         case (state)
            LEC_IDLE :
            begin
               prog_addr <= ADDR_START;
               if (run_sync[1])
                  state <= LEC_FETCH;
            end
            LEC_FETCH :
            begin
               ir    <= prog_word;
               state <= LEC_EXEC;
            end
            LEC_EXEC :
            begin
               // The program is trusted to end in an end opcode
               if (ir[16:13] == OP_END)
               begin
                  state     <= LEC_WRAP;
                  prog_addr <= ADDR_START;
               end
               else
               begin
                  prog_addr <= prog_addr + 8'h01;
                  state     <= LEC_FETCH;
               end
            end
            LEC_WRAP :
            begin
               scan_done <= 1'b1;
               state     <= run_sync[1] ? LEC_FETCH : LEC_IDLE;
            end
            default :
               state <= LEC_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Logic result and bit image
   // ---------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
         acc <= 1'b0;
      else if (state == LEC_EXEC)
         acc <= next_acc;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         bits       <= '0;
         edge_mem   <= '0;
         fp_prev    <= '0;
         first_scan <= 1'b1;
      end
      else
      begin
         if (state == LEC_WRAP)
            first_scan <= 1'b0;
         // Memory is kept per instruction, not per contact: a contact that
         // changes mid-scan, or is read twice, still gives one edge per scan
         if (state == LEC_EXEC && legal && ir[16:13] >= OP_LDR &&
             ir[16:13] <= OP_PFALL)
            edge_mem[prog_addr] <= cur;
         bits[BASE_IN +: N_IN]   <= in_sync;
         bits[BASE_TMR +: N_TMR] <= timer_bits;
         bits[BASE_CNT +: N_CNT] <= counter_bits;
         if (state == LEC_EXEC && ir[16:13] == OP_FPULS && legal)
         begin
            // Pulse held one scan; the condition is sampled per target
            bits[flat]    <= fp_prev[flat] && !acc;
            fp_prev[flat] <= acc;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         outputs       <= '0;
         result        <= 1'b0;
         operand_fault <= 1'b0;
      end
      else
      begin
         outputs <= bits[BASE_OUT +: N_OUT];
         result  <= acc;
         if (state == LEC_EXEC && ir[16:13] != OP_END &&
             ir[16:13] != OP_NOP && !legal)
            operand_fault <= 1'b1;
         else if (state == LEC_WRAP)
            operand_fault <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_end_exec;
      state == LEC_EXEC && ir[16:13] == OP_END;
   endsequence

   AST_END_WRAPS : assert property (@(posedge clock) disable iff (reset)
      s_end_exec |=> state == LEC_WRAP && prog_addr == ADDR_START)
      else $error("end did not return to address 0");
   AST_STEP : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] != OP_END |=>
      prog_addr == $past(prog_addr) + 8'h01)
      else $error("address did not advance");
   AST_DONE : assert property (@(posedge clock) disable iff (reset)
      s_end_exec ##1 1'b1 |=> scan_done)
      else $error("scan end not flagged");
   AST_SRISE : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] == OP_SRISE |=>
      acc == ($past(acc) && $past(rise)))
      else $error("series rise wrong");
   AST_SFALL : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] == OP_SFALL |=>
      acc == ($past(acc) && $past(fall)))
      else $error("series fall wrong");
   AST_PRISE : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] == OP_PRISE |=>
      acc == ($past(acc) || $past(rise)))
      else $error("parallel rise wrong");
   AST_PFALL : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] == OP_PFALL |=>
      acc == ($past(acc) || $past(fall)))
      else $error("parallel fall wrong");
   AST_DATA : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[12:10] == CLS_DATA && ir[16:13] == OP_SRISE
      |=> operand_fault && !acc)
      else $error("data operand accepted");
   AST_LDR : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && ir[16:13] == OP_LDR |=> acc == $past(rise))
      else $error("edge load wrong");
   AST_FIRST : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && first_scan && ir[16:13] == OP_LDR && legal &&
      cur |=> acc)
      else $error("power-up rise missed");
   AST_PULSE : assert property (@(posedge clock) disable iff (reset)
      state == LEC_EXEC && coil_only && legal && !acc && fp_prev[flat]
      |=> bits[$past(flat)])
      else $error("falling pulse not raised");
endmodule
`default_nettype wire

// ### verification/lec_scan_core_tb.sv
// Self-checking bench for the edge contact scan engine
`timescale 1ns/1ps
`default_nettype none
module lec_scan_core_tb;
   import lec_pkg::*;
   logic              clock;
   logic              reset;
   logic              run;
   logic [N_IN-1:0]   inputs;
   logic [N_TMR-1:0]  timer_bits;
   logic [N_CNT-1:0]  counter_bits;
   logic [AW-1:0]     prog_addr;
   logic [16:0]       prog_word;
   logic [N_OUT-1:0]  outputs;
   logic              result;
   logic              scan_done;
   logic              operand_fault;
   logic [16:0]       mem [0:255];
   int                fails;
   int                tests_run;
   int                hits;
   int                yhits;
   int                scans;
   int                addr_bad;
   logic              fault_seen;

   // Program memory is read combinationally at the current address
   assign prog_word = mem[prog_addr];

   lec_scan_core dut_u
   (
      .clock         (clock),
      .reset         (reset),
      .run           (run),
      .inputs        (inputs),
      .timer_bits    (timer_bits),
      .counter_bits  (counter_bits),
      .prog_addr     (prog_addr),
      .prog_word     (prog_word),
      .outputs       (outputs),
      .result        (result),
      .scan_done     (scan_done),
      .operand_fault (operand_fault)
   );

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Scan monitor
   // ------------------------------------------------------------
   // Counting per scan keeps the checks free of the sync latency
   always @(posedge clock)
   begin
      if (scan_done === 1'b1)
      begin
         scans = scans + 1;
         if (result === 1'b1)
            hits = hits + 1;
         if (outputs[3] === 1'b1)
            yhits = yhits + 1;
      end
      if (operand_fault === 1'b1)
         fault_seen = 1'b1;
      if (run === 1'b1 && prog_addr > 8'h02)
         addr_bad = addr_bad + 1;
      // Counters are ints and would read an unknown as zero
      if (reset === 1'b0 &&
          $isunknown({scan_done, result, operand_fault, outputs, prog_addr}))
      begin
         $display("BAD %0t unknown on a design output", $time);
         fails++;
      end
   end

   function automatic logic [16:0] word(input logic [3:0] op,
                                        input logic [2:0] cls,
                                        input logic [9:0] idx);
      return {op, cls, idx};
   endfunction

   task automatic chk(input int got, input int exp, input string msg);
      tests_run++;
      if (got != exp)
      begin
         $display("BAD %0t %s got %0d want %0d", $time, msg, got, exp);
         fails++;
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Shared case: program of two words and end, then one change
   // ------------------------------------------------------------
   task automatic run_case(input string nm, input logic [16:0] w0,
                           input logic [16:0] w1, input logic [15:0] in_a,
                           input logic [15:0] in_b, input logic tc_b,
                           input int exp_hits, input int exp_y,
                           input logic exp_fault);
      @(negedge clock);
      mem[0] = w0;
      mem[1] = w1;
      mem[2] = word(OP_END, CLS_IN, 10'h000);
      inputs = in_a;
      timer_bits = '0;
      counter_bits = '0;
      reset = 1'b1;
      run = 1'b0;
      repeat (5) @(negedge clock);
      hits = 0;
      yhits = 0;
      scans = 0;
      addr_bad = 0;
      fault_seen = 1'b0;
      reset = 1'b0;
      @(negedge clock);
      run = 1'b1;
      repeat (40) @(negedge clock);
      inputs = in_b;
      timer_bits[N_TMR-1] = tc_b;
      counter_bits[N_CNT-1] = tc_b;
      repeat (60) @(negedge clock);
      chk(hits, exp_hits, {nm, " result pulses"});
      chk(yhits, exp_y, {nm, " output pulses"});
      chk(int'(fault_seen), int'(exp_fault), {nm, " operand fault"});
      chk(addr_bad, 0, {nm, " address past end"});
      chk(int'(scans > 4), 1, {nm, " scans restart"});
      $display("Test %s done", nm);
   endtask

   task automatic t_srise();
      run_case("srise", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_SRISE, CLS_IN, 10'h001), 16'h0001, 16'h0003,
               1'b0, 1, 0, 1'b0);
   endtask
   task automatic t_srise_blocked();
      run_case("srise_blocked", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_SRISE, CLS_IN, 10'h001), 16'h0000, 16'h0002,
               1'b0, 0, 0, 1'b0);
   endtask
   task automatic t_sfall();
      run_case("sfall", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_SFALL, CLS_IN, 10'h001), 16'h0003, 16'h0001,
               1'b0, 1, 0, 1'b0);
   endtask
   task automatic t_prise();
      run_case("prise", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_PRISE, CLS_IN, 10'h001), 16'h0000, 16'h0002,
               1'b0, 1, 0, 1'b0);
   endtask
   task automatic t_pfall();
      run_case("pfall", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_PFALL, CLS_IN, 10'h00F), 16'h8000, 16'h0000,
               1'b0, 1, 0, 1'b0);
   endtask
   task automatic t_timer();
      run_case("timer", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_SRISE, CLS_TMR, MAX_TMR), 16'h0001, 16'h0001,
               1'b1, 1, 0, 1'b0);
   endtask
   task automatic t_counter();
      run_case("counter", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_PRISE, CLS_CNT, MAX_CNT), 16'h0000, 16'h0000,
               1'b1, 1, 0, 1'b0);
   endtask
   task automatic t_data_refused();
      run_case("data", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_SRISE, CLS_DATA, 10'h000), 16'h0001, 16'h0003,
               1'b1, 0, 0, 1'b1);
   endtask
   task automatic t_aux_range();
      run_case("aux_range", word(OP_LOAD, CLS_IN, 10'h000),
               word(OP_PRISE, CLS_AUX, 10'h320), 16'h0000, 16'h0000,
               1'b0, 0, 0, 1'b1);
   endtask
   task automatic t_fall_pulse();
      run_case("fall_pulse", word(OP_LDR, CLS_IN, 10'h000),
               word(OP_FPULS, CLS_OUT, 10'h003), 16'h0000, 16'h0001,
               1'b0, 1, 1, 1'b0);
   endtask
   task automatic t_pulse_to_input();
      run_case("pulse_input", word(OP_LDR, CLS_IN, 10'h000),
               word(OP_FPULS, CLS_IN, 10'h003), 16'h0000, 16'h0001,
               1'b0, 1, 0, 1'b1);
   endtask
   task automatic t_power_up();
      run_case("power_up", word(OP_LDR, CLS_IN, 10'h001),
               word(OP_NOP, CLS_IN, 10'h000), 16'h0002, 16'h0002,
               1'b0, 1, 0, 1'b0);
   endtask

   initial
   begin
      reset = 1'b1;
      run = 1'b0;
      inputs = '0;
      timer_bits = '0;
      counter_bits = '0;
      fails = 0;
      tests_run = 0;
      hits = 0;
      yhits = 0;
      scans = 0;
      addr_bad = 0;
      fault_seen = 1'b0;
      // Filler past the end would be fetched only on an overrun
      for (int i = 0; i < 256; i++)
         mem[i] = 17'h00000;
      t_srise();
      t_srise_blocked();
      t_sfall();
      t_prise();
      t_pfall();
      t_timer();
      t_counter();
      t_data_refused();
      t_aux_range();
      t_fall_pulse();
      t_pulse_to_input();
      t_power_up();
      wrap_up();
   end

   // Twelve cases take near ten microseconds
   initial
   begin
      #50000;
      $display("BAD %0t watchdog expired", $time);
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire
